// ### essb_exec_state.sv
// execution-state bits, instruction-set bit and saturation flag of the status word
// Operation
// - saturation flag set by core, cleared only by software status transfer
// - bits 26:25 and 15:10 hold resume field or block state, read-only, reset zero
// - bits 26:25 forced to zero while resume state is held
// - conditional block spans at most four instructions, all conditional
// - each block instruction uses base condition or its inverse
// - bit 24 instruction-set state, read-only, resets to one
// - bit 24 loaded from branch target, stacked word or vector bit zero
// - executing with bit 24 clear raises fault instead
// - execution fields visible only in the stacked/hardware view; software reads in every view return them as zero
// - execution view is bits 26:24 and 15:10; flags 31:27; exception 5:0
// - software reads of execution view return zero, writes ignored
// - interrupted multi-transfer stores next register in 15:12 and resumes there, only when no block or resume state is held
`timescale 1ns/100ps
module essb_exec_state
    import essb_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    // instruction issue and retirement
    input wire logic issue_in,
    input wire logic retire_in,
    // start of a conditional block: base condition and 4-bit then/else mask
    input wire logic block_start_in,
    input wire logic [3:0] block_cond_in,
    input wire logic [3:0] block_mask_in,
    // interrupted multi-transfer
    input wire logic suspend_in,
    input wire logic [3:0] suspend_reg_in,
    input wire logic resume_done_in,
    // instruction-set state loads
    input wire logic branch_load_in,
    input wire logic [31:0] branch_target_in,
    input wire logic exc_return_in,
    input wire logic [31:0] stacked_word_in,
    input wire logic exc_entry_in,
    input wire logic [31:0] vector_in,
    // saturation event and software status transfer
    input wire logic saturate_in,
    input wire logic sw_write_in,
    input wire logic [31:0] sw_wdata_in,
    input wire logic [2:0] sw_view_in,
    // stacked/hardware view and software read
    output logic [31:0] psw_exec_out,
    output logic [31:0] sw_rdata_out,
    output logic cond_valid_out,
    output logic [3:0] cond_out,
    output logic [3:0] resume_reg_out,
    output logic resuming_out,
    output logic fault_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    essb_mode_type mode_reg, mode_next;
    logic iset_reg, iset_next;
    logic q_reg, q_next;
    logic [31:0] psw_reg, psw_next;
    logic [31:0] rd_reg, rd_next;
    logic [3:0] cond_reg, cond_next;
    logic cvalid_reg, cvalid_next;
    logic fault_reg, fault_next;
    logic resuming_reg, resuming_next;
    logic st_load;
    logic [7:0] st_wdata;
    logic [7:0] st_q;
    logic [3:0] base_cond;
    logic [3:0] blk_mask;

    essb_state_store u_store (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .load_in(st_load),
        .data_in(st_wdata),
        .data_out(st_q)
    );

    // packed layout: [7:4]=base cond, [3:0]=mask; resume uses [7:4]=reg
    assign base_cond = st_q[7:4];
    assign blk_mask = st_q[3:0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        mode_next = mode_reg;
        st_load = 1'b0;
        st_wdata = st_q;
        iset_next = iset_reg;
        q_next = q_reg;
        cond_next = cond_reg;
        cvalid_next = 1'b0;
        fault_next = 1'b0;
        if (issue_in && !iset_reg) begin
            fault_next = 1'b1;
        end
        case (mode_reg)
            MODE_IDLE: begin
                if (suspend_in) begin
                    st_load = 1'b1;
                    st_wdata = {suspend_reg_in, MASK_EMPTY};
                    mode_next = MODE_RESUME;
                end else if (block_start_in && block_mask_in != MASK_EMPTY) begin
                    st_load = 1'b1;
                    st_wdata = {block_cond_in, block_mask_in};
                    mode_next = MODE_BLOCK;
                end
            end
            MODE_BLOCK: begin
                // low condition bit flips per instruction via the mask's top bit
                cvalid_next = iset_reg;
                cond_next = {base_cond[3:1], base_cond[0] ^ blk_mask[3]};
                if (retire_in) begin
                    st_load = 1'b1;
                    if (blk_mask[2:0] == 3'h0) begin
                        st_wdata = STATE_RESET;
                        mode_next = MODE_IDLE;
                        cvalid_next = 1'b0;
                    end else begin
                        // shift mask left; the trailing one marks block length
                        st_wdata = {base_cond, blk_mask[2:0], 1'b0};
                    end
                end
            end
            MODE_RESUME: begin
                if (resume_done_in) begin
                    st_load = 1'b1;
                    st_wdata = STATE_RESET;
                    mode_next = MODE_IDLE;
                end
            end
            default: begin
                mode_next = MODE_IDLE;
                st_load = 1'b1;
                st_wdata = STATE_RESET;
            end
        endcase
        // exception entry wins over return, return over branch
        if (exc_entry_in) begin
            iset_next = vector_in[0];
        end else if (exc_return_in) begin
            iset_next = stacked_word_in[ISET_BIT];
        end else if (branch_load_in) begin
            iset_next = branch_target_in[0];
        end
        // set wins over clear so a coincident saturation is not lost
        if (saturate_in) begin
            q_next = 1'b1;
        end else if (sw_write_in && sw_view_in != VIEW_EXEC && !sw_wdata_in[Q_BIT]) begin
            q_next = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // views
    // ------------------------------------------------------------
    always_comb begin
        psw_next = 32'h0000_0000;
        // registered so the output comes straight from a flop
        resuming_next = mode_next == MODE_RESUME;
        psw_next[Q_BIT] = q_next;
        psw_next[ISET_BIT] = iset_next;
        if (mode_next == MODE_RESUME) begin
            psw_next[HI_MSB:HI_LSB] = 2'h0;
            psw_next[LO_MSB:LO_LSB] = {st_wdata[7:4], 2'h0};
        end else begin
            psw_next[HI_MSB:HI_LSB] = st_wdata[1:0];
            psw_next[LO_MSB:LO_LSB] = {st_wdata[7:2]};
        end
        // software never sees execution bits; full and app views carry the flag
        rd_next = 32'h0000_0000;
        if (sw_view_in != VIEW_EXEC) begin
            rd_next[Q_BIT] = q_reg;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            mode_reg <= MODE_IDLE;
            iset_reg <= ISET_RESET;
            q_reg <= Q_RESET;
            psw_reg <= {7'h00, ISET_RESET, 24'h000000};
            rd_reg <= 32'h0000_0000;
            cond_reg <= 4'h0;
            cvalid_reg <= 1'b0;
            fault_reg <= 1'b0;
            resuming_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            iset_reg <= iset_next;
            q_reg <= q_next;
            psw_reg <= psw_next;
            rd_reg <= rd_next;
            cond_reg <= cond_next;
            cvalid_reg <= cvalid_next;
            fault_reg <= fault_next;
            resuming_reg <= resuming_next;
        end
    end

    assign psw_exec_out = psw_reg;
    assign sw_rdata_out = rd_reg;
    assign cond_out = cond_reg;
    assign cond_valid_out = cvalid_reg;
    assign resume_reg_out = psw_reg[REG_MSB:REG_LSB];
    assign resuming_out = resuming_reg;
    assign fault_out = fault_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_sat;
        saturate_in;
    endsequence

    a_sat_set_wins: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_sat |=> q_reg) else $error("saturation flag lost");
    a_resume_hi_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
        mode_reg == MODE_RESUME |-> psw_reg[HI_MSB:HI_LSB] == 2'h0) else $error("resume high bits nonzero");
    a_fault_on_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
        issue_in && !iset_reg |=> fault_out) else $error("no fault on clear state");
    a_sw_read_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
        sw_rdata_out[HI_MSB:ISET_BIT] == 3'h0 && sw_rdata_out[LO_MSB:LO_LSB] == 6'h00)
        else $error("execution bits visible to software");
    a_vec_load: assert property (@(posedge mclk_in) disable iff (rst_in)
        exc_entry_in |=> iset_reg == $past(vector_in[0])) else $error("vector bit not loaded");
    a_resume_reg: assert property (@(posedge mclk_in) disable iff (rst_in)
        mode_reg == MODE_IDLE && suspend_in |=> resume_reg_out == $past(suspend_reg_in))
        else $error("resume register wrong");
    sequence s_four_retires;
        retire_in [*4];
    endsequence

    a_block_len: assert property (@(posedge mclk_in) disable iff (rst_in)
        (mode_reg == MODE_BLOCK) ##0 s_four_retires
        |=> mode_reg == MODE_IDLE) else $error("block exceeds four");
    a_block_end: assert property (@(posedge mclk_in) disable iff (rst_in)
        mode_reg == MODE_IDLE |-> psw_reg[HI_MSB:HI_LSB] == 2'h0 && psw_reg[LO_MSB:LO_LSB] == 6'h00)
        else $error("state not cleared after block");
endmodule

// ### essb_pkg.sv
// constants for the execution-state status bits of the program status word
package essb_pkg;
    localparam int PSW_WIDTH = 32;
    // field positions within program_status_word
    localparam int Q_BIT = 27;
    localparam int ISET_BIT = 24;
    localparam int HI_MSB = 26;
    localparam int HI_LSB = 25;
    localparam int LO_MSB = 15;
    localparam int LO_LSB = 10;
    localparam int REG_MSB = 15;
    localparam int REG_LSB = 12;
    localparam int APP_MSB = 31;
    localparam int APP_LSB = 27;
    localparam int EXC_MSB = 5;
    localparam int EXC_LSB = 0;
    // reset values
    localparam logic [7:0] STATE_RESET = 8'h00;
    localparam logic ISET_RESET = 1'b1;
    localparam logic Q_RESET = 1'b0;
    // status view selectors
    typedef enum logic [2:0] {
        VIEW_FULL = 3'h1,
        VIEW_APP = 3'h2,
        VIEW_EXEC = 3'h4
    } essb_view_type;
    // execution-state holder
    typedef enum logic [2:0] {
        MODE_IDLE = 3'h1,
        MODE_BLOCK = 3'h2,
        MODE_RESUME = 3'h4
    } essb_mode_type;
    localparam logic [3:0] MASK_EMPTY = 4'h0;
    localparam logic [3:0] MASK_END = 4'h8;
endpackage

// ### essb_state_store.sv
// small register that holds the eight packed execution-state bits
`timescale 1ns/100ps
module essb_state_store
    import essb_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out
);
    logic [7:0] data_reg;
    logic [7:0] data_next;

    always_comb begin
        data_next = data_reg;
        if (load_in) begin
            data_next = data_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            data_reg <= STATE_RESET;
        end else begin
            data_reg <= data_next;
        end
    end

    assign data_out = data_reg;
endmodule

// ### tb_execution_state_status_bits.sv
// self-checking bench for the execution-state status bits
`timescale 1ns/100ps
module tb_execution_state_status_bits;
    import essb_pkg::*;
    localparam logic [31:0] EXEC_MASK = 32'h0700FC00;
    logic mclk_in = 0, rst_in = 1, issue_in = 0, retire_in = 0, block_start_in = 0, suspend_in = 0;
    logic resume_done_in = 0, branch_load_in = 0, exc_return_in = 0, exc_entry_in = 0;
    logic saturate_in = 0, sw_write_in = 0, cond_valid_out, resuming_out, fault_out;
    logic [3:0] block_cond_in = 4'h0, block_mask_in = 4'h0, suspend_reg_in = 4'h0, cond_out, resume_reg_out;
    logic [31:0] branch_target_in = 32'h1, stacked_word_in = 32'h0, vector_in = 32'h1, sw_wdata_in = 32'h0;
    logic [31:0] psw_exec_out, sw_rdata_out;
    logic [2:0] sw_view_in = VIEW_FULL;
    int num_errors = 0, checks_done = 0, seed = 32'hEC41;
    essb_exec_state essb_exec_state_i (.mclk_in(mclk_in), .rst_in(rst_in), .issue_in(issue_in),
        .retire_in(retire_in), .block_start_in(block_start_in), .block_cond_in(block_cond_in),
        .block_mask_in(block_mask_in), .suspend_in(suspend_in), .suspend_reg_in(suspend_reg_in),
        .resume_done_in(resume_done_in), .branch_load_in(branch_load_in), .branch_target_in(branch_target_in),
        .exc_return_in(exc_return_in), .stacked_word_in(stacked_word_in), .exc_entry_in(exc_entry_in),
        .vector_in(vector_in), .saturate_in(saturate_in), .sw_write_in(sw_write_in), .sw_wdata_in(sw_wdata_in),
        .sw_view_in(sw_view_in), .psw_exec_out(psw_exec_out), .sw_rdata_out(sw_rdata_out),
        .cond_valid_out(cond_valid_out), .cond_out(cond_out), .resume_reg_out(resume_reg_out),
        .resuming_out(resuming_out), .fault_out(fault_out));
    // ----------------------------------------
    // clock, helpers and expectations
    // ----------------------------------------
    initial begin
        forever #25 mclk_in = ~mclk_in;
    end
    task automatic step();
        @(posedge mclk_in);
        #5;
    endtask
    task automatic chk_word(logic [31:0] got, logic [31:0] exp, string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(logic got, logic exp, string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask
    function automatic logic [31:0] blk_word(logic [3:0] c, logic [3:0] m, logic q);
        return {4'h0, q, m[1:0], 1'b1, 8'h00, c, m[3:2], 10'h000};
    endfunction
    function automatic int ninstr(logic [3:0] m);
        return m[0] ? 4 : m[1] ? 3 : m[2] ? 2 : 1;
    endfunction
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic run_block(logic [3:0] c, logic [3:0] m);
        block_start_in = 1; block_cond_in = c; block_mask_in = m;
        step();
        block_start_in = 0;
        chk_word(psw_exec_out, blk_word(c, m, 1'b0), "block packing");
        suspend_in = 1; suspend_reg_in = 4'h3;
        step();
        suspend_in = 0;
        chk_bit(resuming_out, 1'b0, "suspend inside block");
        step();
        chk_bit(cond_valid_out, 1'b1, "block active");
        chk_word({28'h0, cond_out}, {28'h0, c[3:1], c[0] ^ m[3]}, "first instruction cond");
        // retire held high across back-to-back instructions
        for (int i = 0; i < ninstr(m); i++) begin
            chk_word({29'h0, cond_out[3:1]}, {29'h0, c[3:1]}, "base or inverse cond");
            retire_in = 1;
            step();
        end
        retire_in = 0;
        step();
        step();
        chk_word(psw_exec_out, 32'h01000000, "block cleared");
        chk_bit(cond_valid_out, 1'b0, "block over");
    endtask
    task automatic run_resume(logic [3:0] r);
        suspend_in = 1; suspend_reg_in = r;
        step();
        suspend_in = 0;
        chk_word(psw_exec_out, {8'h01, 8'h00, r, 12'h000}, "resume field");
        chk_bit(resuming_out, 1'b1, "resume held");
        chk_word({28'h0, resume_reg_out}, {28'h0, r}, "resume register");
        chk_word(sw_rdata_out & EXEC_MASK, 32'h0, "software read of exec bits");
        resume_done_in = 1;
        step();
        resume_done_in = 0;
        chk_word(psw_exec_out, 32'h01000000, "resume finished");
    endtask
    initial begin
        #(3000 * 50);
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge mclk_in);
        #5 rst_in = 0;
        chk_word(psw_exec_out, 32'h01000000, "reset word");
        chk_word(sw_rdata_out, 32'h0, "reset read");
        $display("test reset done");
        // saturation flag: sticky until cleared through a flag-carrying view
        saturate_in = 1;
        step();
        saturate_in = 0;
        chk_word(psw_exec_out, 32'h09000000, "saturation set");
        sw_write_in = 1; sw_view_in = VIEW_EXEC; sw_wdata_in = 32'h0;
        step();
        chk_word(psw_exec_out, 32'h09000000, "exec view write");
        sw_view_in = VIEW_FULL; sw_wdata_in = ($random(seed) & 32'h0700FC00) | 32'h08000000;
        step();
        chk_word(psw_exec_out, 32'h09000000, "full write keeps exec bits");
        sw_write_in = 0; sw_view_in = VIEW_APP;
        step();
        step();
        chk_word(sw_rdata_out, 32'h08000000, "app view read");
        sw_view_in = VIEW_EXEC;
        step();
        step();
        chk_word(sw_rdata_out, 32'h0, "exec view read");
        sw_write_in = 1; sw_view_in = VIEW_APP; sw_wdata_in = 32'h0;
        step();
        sw_write_in = 0;
        chk_word(psw_exec_out, 32'h01000000, "saturation cleared");
        $display("test saturation done");
        // instruction-set bit sources and their priority
        branch_load_in = 1; branch_target_in = $random(seed) & 32'hFFFFFFFE;
        step();
        branch_load_in = 0;
        chk_bit(psw_exec_out[24], 1'b0, "branch clears iset");
        issue_in = 1;
        step();
        issue_in = 0;
        chk_bit(fault_out, 1'b1, "issue with iset clear");
        exc_entry_in = 1; vector_in = $random(seed) | 32'h1; exc_return_in = 1; stacked_word_in = 32'h0;
        step();
        exc_entry_in = 0;
        chk_bit(psw_exec_out[24], 1'b1, "vector sets iset");
        branch_load_in = 1; branch_target_in = 32'h1; issue_in = 1;
        step();
        exc_return_in = 0; issue_in = 0;
        chk_bit(fault_out, 1'b0, "issue with iset set");
        chk_bit(psw_exec_out[24], 1'b0, "stacked word beats branch");
        branch_load_in = 1;
        step();
        branch_load_in = 0;
        chk_bit(psw_exec_out[24], 1'b1, "branch sets iset");
        $display("test iset done");
        // conditional blocks and resumable transfers, corners then random
        block_start_in = 1; block_mask_in = 4'h0;
        step();
        block_start_in = 0;
        chk_word(psw_exec_out, 32'h01000000, "zero mask ignored");
        step();
        run_block(4'hE, 4'h8);
        run_block(4'h1, 4'h1);
        run_resume(4'hF);
        for (int k = 0; k < 8; k++) begin
            run_block(4'($random(seed)), 4'($random(seed)) | 4'h1 << (k % 4));
            run_resume(4'($random(seed)));
        end
        $display("test block and resume done");
        // reset in mid-run, with a block open and the flag set
        saturate_in = 1; block_start_in = 1; block_cond_in = 4'h5; block_mask_in = 4'h4;
        step();
        saturate_in = 0; block_start_in = 0; rst_in = 1;
        step();
        step();
        rst_in = 0;
        chk_word(psw_exec_out, 32'h01000000, "mid-run reset word");
        chk_bit(cond_valid_out, 1'b0, "mid-run reset block");
        run_block(4'h5, 4'h4);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
